// ==== hw/ext_regs_pkg.sv ====
// Purpose: shared constants for the extended control register bank
// Assumes: 8-bit indexed host i/o access, one data port with an index register
// Notes: revision codes are parameters of the top module
package ext_regs_pkg;
   localparam logic [15:0] DATA_PORT = 16'h03cf;
   localparam logic [7:0] IDX_BUS_OPTS = 8'ha9;
   localparam logic [7:0] IDX_DESIGN_REV = 8'haa;
   localparam logic [7:0] IDX_MASK_REV = 8'hab;
   localparam logic [7:0] IDX_SCRATCH_FIRST = 8'hba;
   localparam logic [7:0] IDX_SCRATCH_LAST = 8'hbf;
   localparam logic [7:0] IDX_COLOR_CTRL = 8'hc0;
   localparam logic [7:0] IDX_GP_OUT = 8'ha7;
   localparam int SCRATCH_COUNT = 6;
   // writable masks; reserved bits hold zero
   localparam logic [7:0] BUS_OPTS_MASK = 8'h6a;
   localparam logic [7:0] COLOR_CTRL_MASK = 8'h0b;
   localparam logic [7:0] GP_OUT_MASK = 8'h06;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int GP_OUT_A_BIT = 1;
   localparam int GP_OUT_B_BIT = 2;
   localparam int READ_CACHE_BIT = 1;
   localparam int COMPACT_BIT = 3;
   localparam int TIMING_LO = 5;
   localparam int TIMING_HI = 6;
   localparam int FG_ENH_BIT = 0;
   localparam int BYPASS_BIT = 1;
   localparam int BG_ENH_BIT = 3;
   localparam logic [3:0] COLOR_BLACK = 4'h0;
   localparam logic [3:0] COLOR_DARK_GREY = 4'h8;
   localparam logic [3:0] COLOR_LIGHT_GREY = 4'h7;
   localparam int INTENSITY_BIT = 3;
   // internal host interface delays in sequencer clocks per timing code
   localparam logic [1:0] DELAY_CODE0 = 2'h1;
   localparam logic [1:0] DELAY_CODE1 = 2'h2;
   localparam logic [1:0] DELAY_CODE2 = 2'h3;
   localparam logic [1:0] DELAY_CODE3 = 2'h3;
endpackage

// ==== hw/byte_reg.sv ====
// Purpose: one masked writable 8-bit register
// Assumes: synchronous active-high reset
// Notes: bits outside the mask always read zero
`timescale 1ns/1ps
module byte_reg
   import ext_regs_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hff
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] value_q
);
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         value_q <= RESET_VALUE;
      end else if (wr_en) begin
         value_q <= wr_data & MASK;
      end
   end
endmodule

// ==== hw/color_enhance.sv ====
// Purpose: foreground/background enhancement and palette bypass for one pixel
// Assumes: 4-bit colour indices, pixel pipe on the same clock
// Notes: combinational; the caller registers the result
`timescale 1ns/1ps
module color_enhance
   import ext_regs_pkg::*;
(
   input wire logic [7:0] ctrl,
   input wire logic [3:0] fg_in,
   input wire logic [3:0] bg_in,
   output logic [3:0] fg_out,
   output logic [3:0] bg_out,
   output logic use_palette
);
   always_comb begin
      fg_out = fg_in;
      if (ctrl[FG_ENH_BIT] && fg_in != COLOR_BLACK && fg_in != COLOR_DARK_GREY) begin
         fg_out[INTENSITY_BIT] = ~fg_in[INTENSITY_BIT];
      end
      if (ctrl[BG_ENH_BIT]) begin
         bg_out = (fg_in == COLOR_BLACK) ? COLOR_LIGHT_GREY : COLOR_BLACK;
      end else begin
         bg_out = bg_in;
      end
      use_palette = ~ctrl[BYPASS_BIT];
   end
endmodule

// ==== hw/ext_ctrl_regs.sv ====
// Purpose: indexed extended control registers behind host data port
// Assumes: host i/o strobes and address come from pins, sampled twice
// Notes: one access per strobe; index written separately on its own port pin
`timescale 1ns/1ps
module ext_ctrl_regs
   import ext_regs_pkg::*;
#(
   parameter logic [7:0] DESIGN_REV = 8'h5a,  // arbitrary value
   parameter logic [7:0] MASK_REV = 8'h3c     // arbitrary value
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [15:0] io_addr,
   input wire logic io_wr_n,
   input wire logic io_rd_n,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] ext_index,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   output logic user_output_a,
   output logic user_output_b,
   output logic [1:0] host_interface_timing,
   output logic [1:0] host_delay_cycles,
   input wire logic [1:0] write_mode,
   output logic compaction_active,
   output logic read_cache_en,
   input wire logic [3:0] fg_color,
   input wire logic [3:0] bg_color,
   output logic [3:0] fg_color_out,
   output logic [3:0] bg_color_out,
   output logic palette_lookup_en
);
   logic [15:0] addr_s1_q, addr_s2_q;
   logic [7:0] wdata_s1_q, wdata_s2_q, index_s1_q, index_s2_q;
   logic [1:0] wr_sync_q, rd_sync_q;
   logic wr_prev_q, rd_prev_q;
   logic wr_pulse, rd_level, port_hit;
   logic [7:0] bus_opts_q, color_ctrl_q, gp_out_q;
   logic [7:0] scratch_q [SCRATCH_COUNT];
   logic [7:0] rd_mux;
   logic [3:0] fg_next, bg_next;
   logic pal_next;

   typedef enum logic [1:0] {IDLE = 2'b00, WRITE = 2'b01, READ = 2'b10} acc_state_t;
   acc_state_t state_q, state_d;

   // pins are asynchronous to ref_clk; two stages before use
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         addr_s1_q <= 16'h0000;
         addr_s2_q <= 16'h0000;
         wdata_s1_q <= 8'h00;
         wdata_s2_q <= 8'h00;
         index_s1_q <= 8'h00;
         index_s2_q <= 8'h00;
         wr_sync_q <= 2'h3;
         rd_sync_q <= 2'h3;
      end else begin
         addr_s1_q <= io_addr;
         addr_s2_q <= addr_s1_q;
         wdata_s1_q <= io_wdata;
         wdata_s2_q <= wdata_s1_q;
         index_s1_q <= ext_index;
         index_s2_q <= index_s1_q;
         wr_sync_q <= {wr_sync_q[0], io_wr_n};
         rd_sync_q <= {rd_sync_q[0], io_rd_n};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
      end else begin
         wr_prev_q <= wr_sync_q[1];
         rd_prev_q <= rd_sync_q[1];
      end
   end

   assign port_hit = (addr_s2_q == DATA_PORT);
   assign rd_level = port_hit && !rd_sync_q[1];

   always_comb begin
      state_d = IDLE;
      case (state_q)
         IDLE: begin
            if (port_hit && wr_prev_q && !wr_sync_q[1]) begin
               state_d = WRITE;
            end else if (rd_level) begin
               state_d = READ;
            end
         end
         WRITE: state_d = IDLE;
         READ: state_d = rd_level ? READ : IDLE;
         default: state_d = IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign wr_pulse = (state_q == WRITE);

   byte_reg #(.MASK(BUS_OPTS_MASK)) u_bus_opts (
      .ref_clk(ref_clk),
      .reset(reset),
      .wr_en(wr_pulse && index_s2_q == IDX_BUS_OPTS),
      .wr_data(wdata_s2_q),
      .value_q(bus_opts_q)
   );

   byte_reg #(.MASK(COLOR_CTRL_MASK)) u_color_ctrl (
      .ref_clk(ref_clk),
      .reset(reset),
      .wr_en(wr_pulse && index_s2_q == IDX_COLOR_CTRL),
      .wr_data(wdata_s2_q),
      .value_q(color_ctrl_q)
   );

   byte_reg #(.MASK(GP_OUT_MASK)) u_gp_out (
      .ref_clk(ref_clk),
      .reset(reset),
      .wr_en(wr_pulse && index_s2_q == IDX_GP_OUT),
      .wr_data(wdata_s2_q),
      .value_q(gp_out_q)
   );

   for (genvar i = 0; i < SCRATCH_COUNT; i++) begin : g_scratch
      byte_reg #(.MASK(8'hff)) u_scr (
         .ref_clk(ref_clk),
         .reset(reset),
         .wr_en(wr_pulse && index_s2_q == IDX_SCRATCH_FIRST + 8'(i)),
         .wr_data(wdata_s2_q),
         .value_q(scratch_q[i])
      );
   end

   always_comb begin
      rd_mux = 8'h00;
      if (index_s2_q >= IDX_SCRATCH_FIRST && index_s2_q <= IDX_SCRATCH_LAST) begin
         rd_mux = scratch_q[3'(index_s2_q - IDX_SCRATCH_FIRST)];
      end else begin
         case (index_s2_q)
            IDX_BUS_OPTS: rd_mux = bus_opts_q;
            IDX_DESIGN_REV: rd_mux = DESIGN_REV;
            IDX_MASK_REV: rd_mux = MASK_REV;
            IDX_COLOR_CTRL: rd_mux = color_ctrl_q;
            IDX_GP_OUT: rd_mux = gp_out_q;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         io_rdata <= 8'h00;
      end else begin
         io_rdata <= rd_mux;
      end
   end

   // read data is registered every cycle, so it has settled when the read state starts
   assign io_rdata_oe = (state_q == READ);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         user_output_a <= 1'b0;
         user_output_b <= 1'b0;
      end else begin
         user_output_a <= gp_out_q[GP_OUT_A_BIT];
         user_output_b <= gp_out_q[GP_OUT_B_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         host_interface_timing <= 2'h0;
         host_delay_cycles <= DELAY_CODE0;
         compaction_active <= 1'b0;
         read_cache_en <= 1'b0;
      end else begin
         host_interface_timing <= bus_opts_q[TIMING_HI:TIMING_LO];
         case (bus_opts_q[TIMING_HI:TIMING_LO])
            2'h0: host_delay_cycles <= DELAY_CODE0;
            2'h1: host_delay_cycles <= DELAY_CODE1;
            2'h2: host_delay_cycles <= DELAY_CODE2;
            default: host_delay_cycles <= DELAY_CODE3;
         endcase
         compaction_active <= bus_opts_q[COMPACT_BIT] && write_mode[1];
         read_cache_en <= bus_opts_q[READ_CACHE_BIT];
      end
   end

   color_enhance u_color (
      .ctrl(color_ctrl_q),
      .fg_in(fg_color),
      .bg_in(bg_color),
      .fg_out(fg_next),
      .bg_out(bg_next),
      .use_palette(pal_next)
   );

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fg_color_out <= 4'h0;
         bg_color_out <= 4'h0;
         palette_lookup_en <= 1'b1;
      end else begin
         fg_color_out <= fg_next;
         bg_color_out <= bg_next;
         palette_lookup_en <= pal_next;
      end
   end

   AST_PINS_FOLLOW:
   assert property (@(posedge ref_clk) disable iff (reset)
      ##1 user_output_a == $past(gp_out_q[GP_OUT_A_BIT])
         && user_output_b == $past(gp_out_q[GP_OUT_B_BIT]))
      else $error("output pins do not follow control bits");

   AST_OPTS_WRITE:
   assert property (@(posedge ref_clk) disable iff (reset)
      (wr_pulse && index_s2_q == IDX_BUS_OPTS) |=> bus_opts_q == ($past(wdata_s2_q) & BUS_OPTS_MASK))
      else $error("options write not taken");

   AST_TIMING_CODE:
   assert property (@(posedge ref_clk) disable iff (reset)
      ($past(bus_opts_q[TIMING_HI:TIMING_LO]) == 2'h1) |-> host_delay_cycles == DELAY_CODE1)
      else $error("delay code mismatch");

   AST_COMPACT_OFF:
   assert property (@(posedge ref_clk) disable iff (reset)
      !bus_opts_q[COMPACT_BIT] |=> !compaction_active)
      else $error("compaction with bit clear");

   AST_CACHE_OFF:
   assert property (@(posedge ref_clk) disable iff (reset)
      !bus_opts_q[READ_CACHE_BIT] |=> !read_cache_en)
      else $error("read cache with bit clear");

   AST_DESIGN_REV:
   assert property (@(posedge ref_clk) disable iff (reset)
      (index_s2_q == IDX_DESIGN_REV) |=> io_rdata == DESIGN_REV)
      else $error("design revision wrong");

   AST_MASK_REV:
   assert property (@(posedge ref_clk) disable iff (reset)
      (index_s2_q == IDX_MASK_REV) |=> io_rdata == MASK_REV)
      else $error("mask revision wrong");

   AST_SCRATCH_HOLD:
   assert property (@(posedge ref_clk) disable iff (reset)
      !wr_pulse |=> $stable(scratch_q[0]) && $stable(scratch_q[5]))
      else $error("scratch changed without write");

   AST_BG_ENH:
   assert property (@(posedge ref_clk) disable iff (reset)
      (color_ctrl_q[BG_ENH_BIT] && fg_color == COLOR_BLACK) |=> bg_color_out == COLOR_LIGHT_GREY)
      else $error("background not forced");

   AST_BYPASS:
   assert property (@(posedge ref_clk) disable iff (reset)
      ##1 palette_lookup_en == !$past(color_ctrl_q[BYPASS_BIT]))
      else $error("palette bypass wrong");

   AST_FG_ENH:
   assert property (@(posedge ref_clk) disable iff (reset)
      (color_ctrl_q[FG_ENH_BIT] && fg_color == COLOR_DARK_GREY) |=> fg_color_out == COLOR_DARK_GREY)
      else $error("grey foreground altered");

   AST_TIMING_COPY:
   assert property (@(posedge ref_clk) disable iff (reset)
      ##1 host_interface_timing == $past(bus_opts_q[TIMING_HI:TIMING_LO]))
      else $error("timing field not copied");

   AST_DELAY_CODE2:
   assert property (@(posedge ref_clk) disable iff (reset)
      ($past(bus_opts_q[TIMING_HI:TIMING_LO]) == 2'h2) |-> host_delay_cycles == DELAY_CODE2)
      else $error("delay code two mismatch");

   AST_COMPACT_ON:
   assert property (@(posedge ref_clk) disable iff (reset)
      (bus_opts_q[COMPACT_BIT] && write_mode[1]) |=> compaction_active)
      else $error("compaction missing in modes 2 and 3");

   AST_COMPACT_MODE:
   assert property (@(posedge ref_clk) disable iff (reset)
      !write_mode[1] |=> !compaction_active)
      else $error("compaction outside modes 2 and 3");

   AST_CACHE_ON:
   assert property (@(posedge ref_clk) disable iff (reset)
      bus_opts_q[READ_CACHE_BIT] |=> read_cache_en)
      else $error("read cache not enabled");

   AST_SCRATCH_WRITE:
   assert property (@(posedge ref_clk) disable iff (reset)
      (wr_pulse && index_s2_q == IDX_SCRATCH_LAST)
      |=> scratch_q[SCRATCH_COUNT - 1] == $past(wdata_s2_q))
      else $error("last scratch write not taken");

   AST_BG_ZERO:
   assert property (@(posedge ref_clk) disable iff (reset)
      (color_ctrl_q[BG_ENH_BIT] && fg_color != COLOR_BLACK) |=> bg_color_out == COLOR_BLACK)
      else $error("background not forced to zero");

   AST_FG_FLIP:
   assert property (@(posedge ref_clk) disable iff (reset)
      (color_ctrl_q[FG_ENH_BIT] && fg_color != COLOR_BLACK && fg_color != COLOR_DARK_GREY)
      |=> fg_color_out[INTENSITY_BIT] != $past(fg_color[INTENSITY_BIT]))
      else $error("foreground intensity not flipped");

   AST_RESET_CLEAR:
   assert property (@(posedge ref_clk) reset |=> bus_opts_q == RESET_VALUE
      && color_ctrl_q == RESET_VALUE && scratch_q[2] == RESET_VALUE)
      else $error("reset did not clear");
endmodule

// ==== verification/host_io_model.sv ====
// Purpose: host i/o master for the extended register data port
// Assumes: index and data set up two cycles before the strobe falls
// Notes: released data bus shows the inverse of its last value, never a stale copy
`timescale 1ns/1ps
module host_io_model (
   input wire logic ref_clk,
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_oe,
   output logic [15:0] io_addr,
   output logic io_wr_n,
   output logic io_rd_n,
   output logic [7:0] io_wdata,
   output logic [7:0] ext_index
);
   // strobes idle high so nothing is taken while reset drops
   initial begin
      io_addr = 16'h0000;
      io_wr_n = 1'b1;
      io_rd_n = 1'b1;
      io_wdata = 8'h00;
      ext_index = 8'h00;
   end

   // reserved bits: callers pass zero there except in refusal checks
   // the bench stands in for firmware, the only caller meant to change the options byte
   task automatic setup(input logic [15:0] a, input logic [7:0] idx, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      io_addr = a;
      ext_index = idx;
      io_wdata = d;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   // high time between strobes, then the bus is let go
   task automatic gap();
      repeat (3) @(posedge ref_clk);
      #1;
      io_wdata = ~io_wdata;
   endtask

   task automatic io_write(input logic [15:0] a, input logic [7:0] idx, input logic [7:0] d,
         input int slow);
      setup(a, idx, d);
      io_wr_n = 1'b0;
      repeat (4 + slow) @(posedge ref_clk);
      #1;
      io_wr_n = 1'b1;
      gap();
   endtask

   // the answer is taken at the edge where the output enable is seen high
   task automatic io_read(input logic [15:0] a, input logic [7:0] idx, output logic [7:0] d,
         output logic ok, input int slow);
      setup(a, idx, io_wdata);
      io_rd_n = 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge ref_clk);
         ok = (io_rdata_oe === 1'b1);
         d = io_rdata;
      end
      repeat (slow) @(posedge ref_clk);
      #1;
      io_rd_n = 1'b1;
      gap();
   endtask
endmodule

// ==== verification/vga_extended_control_regs_test.sv ====
// Purpose: self-checking bench for the extended control register bank
// Assumes: host model drives the data port; pixel and mode inputs driven here
// Notes: revision parameters get arbitrary values of our own
`timescale 1ns/1ps
module vga_extended_control_regs_test
   import ext_regs_pkg::*;
;
   localparam logic [7:0] REV_D = 8'h96;  // arbitrary value
   localparam logic [7:0] REV_M = 8'h4e;  // arbitrary value
   logic ref_clk, reset, io_wr_n, io_rd_n, io_rdata_oe, user_output_a, user_output_b;
   logic compaction_active, read_cache_en, palette_lookup_en;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, ext_index, io_rdata, d;
   logic [1:0] host_interface_timing, host_delay_cycles, write_mode;
   logic [3:0] fg_color, bg_color, fg_color_out, bg_color_out, ef, eb;
   logic ok;
   int n_fail = 0;
   int check_count = 0;
   logic [1:0] dly[4] = '{DELAY_CODE0, DELAY_CODE1, DELAY_CODE2, DELAY_CODE3};
   logic [7:0] cv[6] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0b, 8'hff};

   ext_ctrl_regs #(.DESIGN_REV(REV_D), .MASK_REV(REV_M)) u_ext_ctrl_regs (.ref_clk(ref_clk),
      .reset(reset), .io_addr(io_addr), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n),
      .io_wdata(io_wdata), .ext_index(ext_index), .io_rdata(io_rdata),
      .io_rdata_oe(io_rdata_oe), .user_output_a(user_output_a), .user_output_b(user_output_b),
      .host_interface_timing(host_interface_timing), .host_delay_cycles(host_delay_cycles),
      .write_mode(write_mode), .compaction_active(compaction_active),
      .read_cache_en(read_cache_en), .fg_color(fg_color), .bg_color(bg_color),
      .fg_color_out(fg_color_out), .bg_color_out(bg_color_out),
      .palette_lookup_en(palette_lookup_en));
   host_io_model u_host_io_model (.ref_clk(ref_clk), .io_rdata(io_rdata),
      .io_rdata_oe(io_rdata_oe), .io_addr(io_addr), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n),
      .io_wdata(io_wdata), .ext_index(ext_index));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] v, input int slow);
      u_host_io_model.io_write(DATA_PORT, idx, v, slow);
   endtask

   // a read that never answers ends the run
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      u_host_io_model.io_read(DATA_PORT, idx, d, ok, 0);
      if (ok !== 1'b1) begin
         n_fail++;
         give_verdict();
      end
      chk(d, exp);
   endtask

   task automatic check_reset();
      rd(IDX_BUS_OPTS, RESET_VALUE);
      rd(IDX_COLOR_CTRL, RESET_VALUE);
      for (int i = 0; i < SCRATCH_COUNT; i++) rd(IDX_SCRATCH_FIRST + 8'(i), RESET_VALUE);
      chk({4'h0, user_output_b, user_output_a, palette_lookup_en, read_cache_en}, 8'h02);
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk);
      n_fail++;
      give_verdict();
   end

   initial begin
      reset = 1'b1;
      write_mode = 2'h0;
      fg_color = 4'h0;
      bg_color = 4'h0;
      repeat (8) @(posedge ref_clk);
      #1 reset = 1'b0;
      check_reset();
      for (int i = 0; i < 4; i++) begin
         wr(IDX_GP_OUT, 8'(i << 1), 0);
         chk({6'h0, user_output_b, user_output_a}, 8'(i));
      end
      wr(IDX_BUS_OPTS, 8'hff, 0);
      rd(IDX_BUS_OPTS, BUS_OPTS_MASK);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_BUS_OPTS, {1'b0, 2'(i), 3'b000, i[0], 1'b0}, 0);
         rd(IDX_BUS_OPTS, {1'b0, 2'(i), 3'b000, i[0], 1'b0});
         chk({6'h0, host_interface_timing}, 8'(i));
         chk({6'h0, host_delay_cycles}, {6'h0, dly[i]});
         chk({7'h0, read_cache_en}, 8'(i & 1));
      end
      for (int c = 0; c < 2; c++) begin
         wr(IDX_BUS_OPTS, c == 1 ? 8'h08 : 8'h00, 0);
         for (int m = 0; m < 4; m++) begin
            write_mode = 2'(m);
            repeat (2) @(posedge ref_clk);
            #1;
            chk({7'h0, compaction_active}, 8'((c == 1 && m >= 2) ? 1 : 0));
         end
      end
      rd(IDX_DESIGN_REV, REV_D);
      rd(IDX_MASK_REV, REV_M);
      wr(IDX_DESIGN_REV, ~REV_D, 0);
      wr(IDX_MASK_REV, ~REV_M, 0);
      rd(IDX_DESIGN_REV, REV_D);
      rd(IDX_MASK_REV, REV_M);
      rd(8'hb0, 8'h00);
      // slower holds on later scratch writes exercise long strobes
      for (int i = 0; i < SCRATCH_COUNT; i++) begin
         wr(IDX_SCRATCH_FIRST + 8'(i), 8'ha0 + 8'(i), i);
      end
      for (int i = 0; i < SCRATCH_COUNT; i++) rd(IDX_SCRATCH_FIRST + 8'(i), 8'ha0 + 8'(i));
      chk({4'h0, user_output_b, user_output_a, palette_lookup_en, compaction_active}, 8'h0f);
      // wrong port: neither taken nor answered
      u_host_io_model.io_write(16'h03ce, IDX_SCRATCH_FIRST, 8'h11, 0);
      rd(IDX_SCRATCH_FIRST, 8'ha0);
      u_host_io_model.io_read(16'h03ce, IDX_SCRATCH_FIRST, d, ok, 0);
      chk({7'h0, ok}, 8'h00);
      foreach (cv[k]) begin
         wr(IDX_COLOR_CTRL, cv[k], 0);
         rd(IDX_COLOR_CTRL, cv[k] & COLOR_CTRL_MASK);
         chk({7'h0, palette_lookup_en}, {7'h0, ~cv[k][1]});
         for (int f = 0; f < 16; f++) begin
            fg_color = 4'(f);
            bg_color = 4'(15 - f);
            ef = (cv[k][0] && f != 0 && f != 8) ? 4'(f) ^ 4'h8 : 4'(f);
            eb = cv[k][3] ? (f == 0 ? 4'h7 : 4'h0) : 4'(15 - f);
            @(posedge ref_clk);
            #1;
            chk({fg_color_out, bg_color_out}, {ef, eb});
         end
      end
      reset = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 reset = 1'b0;
      check_reset();
      give_verdict();
   end
endmodule
